//--- shared/sfp_pkg.sv
// constants, register layout and types of the four-mode serial port
package sfp_pkg;
	localparam int DATA_W = 32;                           // bus data width
	localparam int ADDR_W = 32;                           // bus address width
	localparam int DEC_W  = 8;                            // decoded low address bits

	// register byte addresses
	localparam logic [7:0] ADDR_CTRL   = 8'h00;          // serial_control
	localparam logic [7:0] ADDR_DATA   = 8'h04;          // serial_data_buffer
	localparam logic [7:0] ADDR_CFG    = 8'h08;          // rate and source configuration
	localparam logic [7:0] ADDR_RELOAD = 8'h0c;          // timer 2 reload value

	// serial_control layout, msb first
	typedef struct packed {
		logic mode_select_hi;                             // mode bit, upper
		logic mode_select_lo;                             // mode bit, lower
		logic multiproc_filter;                           // address filter / mode 0 fast rate
		logic rx_enable;                                  // receive allowed
		logic tx_ninth_bit;                               // ninth bit to send
		logic rx_ninth_bit;                               // ninth or stop bit received
		logic transmit_done_flag;                         // frame sent
		logic receive_done_flag;                          // frame received
	} sfp_ctrl_t;
	localparam logic [7:0] CTRL_RST = 8'h00;

	// configuration register layout, msb first
	typedef struct packed {
		logic serial_irq_enable;                          // serial interrupt enable
		logic global_irq_enable;                          // global interrupt enable
		logic timer2_ext_count;                           // timer 2 counts the external pin
		logic rx_timer2_select;                           // receiver clocked by timer 2
		logic tx_timer2_select;                           // transmitter clocked by timer 2
		logic timer1_fast_sel;                            // timer 1 counts every 4 clocks
		logic double_rate_sel;                            // skip the extra divide by two
	} sfp_cfg_t;
	localparam int         CFG_W   = 7;
	localparam logic [6:0] CFG_RST = 7'h00;
	localparam logic [15:0] RELOAD_RST = 16'h0000;
	localparam logic [15:0] T2_MAX     = 16'hffff;

	// serial modes from {mode_select_hi, mode_select_lo}
	localparam logic [1:0] MODE0 = 2'b00;
	localparam logic [1:0] MODE1 = 2'b01;
	localparam logic [1:0] MODE2 = 2'b10;
	localparam logic [1:0] MODE3 = 2'b11;

	// timing counts in core clocks
	localparam logic [3:0] M0_SLOW_LAST = 4'hb;          // clk/12 shift
	localparam logic [3:0] M0_SLOW_HALF = 4'h6;
	localparam logic [3:0] M0_FAST_LAST = 4'h3;          // clk/4 shift
	localparam logic [3:0] M0_FAST_HALF = 4'h2;
	localparam logic [3:0] T1_SLOW_LAST = 4'hb;          // timer 1 every 12 clocks
	localparam logic [3:0] T1_FAST_LAST = 4'h3;          // timer 1 every 4 clocks
	localparam logic [1:0] M2_SLOW_LAST = 2'h3;          // mode 2 oversample every 4 clocks
	localparam logic [1:0] M2_FAST_LAST = 2'h1;          // mode 2 oversample every 2 clocks
	localparam int         TI_DELAY     = 2;             // mode 1 done delay, clocks

	// oversampling positions within a bit
	localparam logic [3:0] OS_LAST  = 4'hf;
	localparam logic [3:0] OS_MID_A = 4'h7;
	localparam logic [3:0] OS_MID_B = 4'h8;
	localparam logic [3:0] OS_MID_C = 4'h9;

	// frame bit indices (start bit is 0)
	localparam logic [3:0] M0_LAST_BIT  = 4'h7;
	localparam logic [3:0] DATA_LAST    = 4'h8;
	localparam logic [3:0] NINTH_BIT    = 4'h9;
	localparam logic [3:0] STOP_BIT_10  = 4'h9;
	localparam logic [3:0] STOP_BIT_11  = 4'ha;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_WAIT = 2'b01,
		TX_SEND = 2'b11,
		TX_SYNC = 2'b10
	} sfp_tx_state_t;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_ASYNC = 2'b01,
		RX_SPARE = 2'b11
	} sfp_rx_state_t;
endpackage

//--- rtl/sfp_serial_port.sv
// four-mode serial port with ahb-lite register access
//
// The implementer's own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// RULE_01 - two control bits select modes zero to three
// RULE_02 - filter drops mode 2/3 frames with ninth zero
// RULE_03 - receive only while receive enable set
// RULE_04 - modes 2/3 send control ninth bit
// RULE_05 - store ninth bit, or stop bit in mode 1
// RULE_06 - transmit done at mode 0 end or stop
// RULE_07 - receive done in mode 0; interrupt when enabled
// RULE_08 - mode 0 shifts at clk/12 or clk/4
// RULE_09 - mode 0 write sends eight bits lsb first
// RULE_10 - mode 0 receive eight bits, flag, then halt
// RULE_11 - mode 1 ten-bit frame, full duplex
// RULE_12 - timer overflow divided by sixteen gives bit rate
// RULE_13 - timer 1 overflow halved unless double rate
// RULE_14 - timer 1 counts every 4 or 12 clocks
// RULE_15 - timer 2 select per direction, reload based rate
// RULE_16 - transmit starts at next divide-by-16 rollover
// RULE_17 - mode 1 transmit done two clocks after stop
// RULE_18 - sixteen samples per bit, realign on start edge
// RULE_19 - majority of three; false start abandons reception
// RULE_20 - mid-stop checks decide load or discard
// RULE_21 - mode 2 eleven-bit frame with ninth bit
// RULE_22 - mode 3 uses mode 2 frame, timer rate
// RULE_23 - timer 2 baud counter runs at clk/2
// RULE_24 - mode 2 rate fixed fraction of core clock
// RULE_25 - modes 2/3 filter on received ninth bit
module sfp_serial_port
(
	input  wire logic                        ref_clk_i,      // core clock
	input  wire logic                        srst_i,         // synchronous reset
	input  wire logic                        hsel_i,         // slave select
	input  wire logic [sfp_pkg::ADDR_W-1:0]  haddr_i,        // byte address
	input  wire logic [1:0]                  htrans_i,       // transfer type
	input  wire logic                        hwrite_i,       // write when high
	input  wire logic [2:0]                  hsize_i,        // transfer size
	input  wire logic [sfp_pkg::DATA_W-1:0]  hwdata_i,       // write data
	input  wire logic                        hready_i,       // bus ready
	output logic      [sfp_pkg::DATA_W-1:0]  hrdata_o,       // read data
	output logic                             hreadyout_o,    // slave ready
	output logic                             hresp_o,        // always okay
	input  wire logic                        rxd_i,          // serial data in
	output logic                             rxd_o,          // mode 0 data out
	output logic                             rxd_oe_o,       // mode 0 data drive enable
	output logic                             txd_o,          // serial out / mode 0 shift clock
	input  wire logic                        timer1_ovf_i,   // timer 1 overflow pulse
	input  wire logic                        t2_ext_i,       // timer 2 external count pin
	output logic                             timer1_tick_o,  // timer 1 count enable pulse
	output logic                             serial_irq_o    // serial interrupt request
);
	import sfp_pkg::*;

	sfp_ctrl_t         serial_control;     // control and flag register
	sfp_cfg_t          cfg;                // rate and source configuration
	logic [15:0]       timer2_reload;      // timer 2 reload value
	logic [7:0]        serial_data_buffer; // received byte
	logic [1:0]        mode;               // current serial mode
	logic              wr_pend;            // write data phase pending
	logic [DEC_W-1:0]  wr_addr;            // address of the pending write
	logic              ctrl_wr;            // control register write strobe
	logic              data_wr;            // data buffer write strobe
	logic              rd_req;             // read address phase taken

	// baud generation
	logic [3:0]        t1_pre;             // timer 1 prescaler
	logic              t1_half;            // timer 1 overflow halving toggle
	logic              t1_os;              // timer 1 derived oversample tick
	logic [1:0]        m2_pre;             // mode 2 oversample prescaler
	logic              m2_os;              // mode 2 oversample tick
	logic              t2_half;            // timer 2 clk/2 toggle
	logic              t2_ext_q;           // previous external pin level
	logic              t2_adv;             // timer 2 advance
	logic [15:0]       t2_cnt;             // timer 2 count
	logic              t2_ovf;             // timer 2 overflow
	logic              tx_os;              // transmit oversample tick
	logic              rx_os;              // receive oversample tick
	logic [3:0]        tx_div;             // transmit divide-by-16
	logic              tx_roll;            // transmit bit boundary

	// transmitter and mode 0 engine
	sfp_tx_state_t     tx_state;           // transmit / mode 0 state
	logic [10:0]       tx_sh;              // frame shift register
	logic [3:0]        tx_bit;             // bit on the line
	logic [3:0]        tx_last;            // index of the stop bit
	logic [3:0]        m0_cnt;             // mode 0 bit phase
	logic [3:0]        m0_last;            // mode 0 bit length minus one
	logic [3:0]        m0_half;            // mode 0 rising shift clock phase
	logic              m0_rx;              // mode 0 engine is receiving
	logic              m0_rx_done;         // mode 0 byte received pulse
	logic              stop_place;         // stop bit goes on the line now
	logic              m0_tx_end;          // mode 0 eighth bit ends now
	logic [TI_DELAY-1:0] ti_dly;           // mode 1 done delay line
	logic              ti_set;             // hardware sets transmit done

	// receiver
	sfp_rx_state_t     rx_state;           // asynchronous receive state
	logic [3:0]        rx_div;             // receive divide-by-16
	logic [3:0]        rx_bit;             // frame bit index
	logic [3:0]        rx_stop;            // index of the stop bit
	logic              rx_prev;            // previous line sample
	logic              smp_a;              // first mid-bit sample
	logic              smp_b;              // second mid-bit sample
	logic              vote;               // majority of three samples
	logic [7:0]        rx_sh;              // data shift register
	logic              rx_ninth;           // received ninth bit
	logic              flag_bit;           // bit tested by the filter
	logic              rx_accept;          // frame accepted at mid stop
	logic              ri_set;             // hardware sets receive done

	assign mode = {serial_control.mode_select_hi, serial_control.mode_select_lo}; // RULE_01

	// ---------------- bus slave ----------------

	// register the address phase of writes
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			wr_pend <= 1'b0;
			wr_addr <= '0;
		end
		else
		begin
			wr_pend <= hsel_i & hready_i & htrans_i[1] & hwrite_i;
			wr_addr <= haddr_i[DEC_W-1:0];
		end
	end

	assign ctrl_wr = wr_pend & (wr_addr == ADDR_CTRL);
	assign data_wr = wr_pend & (wr_addr == ADDR_DATA);
	assign rd_req  = hsel_i & hready_i & htrans_i[1] & ~hwrite_i;

	// read data prepared in the address phase; no wait states
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			hrdata_o    <= '0;
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end
		else
		begin
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
			if (rd_req)
			begin
				case (haddr_i[DEC_W-1:0])
					ADDR_CTRL:   hrdata_o <= {24'h000000, serial_control};
					ADDR_DATA:   hrdata_o <= {24'h000000, serial_data_buffer};
					ADDR_CFG:    hrdata_o <= {25'h0, cfg};
					ADDR_RELOAD: hrdata_o <= {16'h0000, timer2_reload};
					default:     hrdata_o <= '0;   // unmapped reads zero
				endcase
			end
			else
				hrdata_o <= '0;
		end
	end

	// control register; hardware sets win over a software clear
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
			serial_control <= sfp_ctrl_t'(CTRL_RST);
		else
		begin
			if (ctrl_wr)
				serial_control <= sfp_ctrl_t'(hwdata_i[7:0]);
			if (rx_accept)
				serial_control.rx_ninth_bit <= flag_bit;           // RULE_05
			if (ti_set)
				serial_control.transmit_done_flag <= 1'b1;         // RULE_06
			if (ri_set)
				serial_control.receive_done_flag <= 1'b1;          // RULE_07
		end
	end

	// configuration and reload registers
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			cfg           <= sfp_cfg_t'(CFG_RST);
			timer2_reload <= RELOAD_RST;
		end
		else
		begin
			if (wr_pend && wr_addr == ADDR_CFG)
				cfg <= sfp_cfg_t'(hwdata_i[CFG_W-1:0]);
			if (wr_pend && wr_addr == ADDR_RELOAD)
				timer2_reload <= hwdata_i[15:0];
		end
	end

	// interrupt request while a flag is set and both enables are on
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
			serial_irq_o <= 1'b0;
		else
			serial_irq_o <= (serial_control.receive_done_flag | serial_control.transmit_done_flag)
				& cfg.global_irq_enable & cfg.serial_irq_enable;   // RULE_07
	end

	// ---------------- baud generation ----------------

	// timer 1 count enable every 12 or 4 clocks
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			t1_pre        <= '0;
			timer1_tick_o <= 1'b0;
		end
		else if (t1_pre == (cfg.timer1_fast_sel ? T1_FAST_LAST : T1_SLOW_LAST)) // RULE_14
		begin
			t1_pre        <= '0;
			timer1_tick_o <= 1'b1;
		end
		else
		begin
			t1_pre        <= t1_pre + 4'h1;
			timer1_tick_o <= 1'b0;
		end
	end

	// timer 1 overflow halving, bypassed by double rate
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
			t1_half <= 1'b0;
		else if (timer1_ovf_i)
			t1_half <= ~t1_half;
	end

	assign t1_os = timer1_ovf_i & (cfg.double_rate_sel | t1_half);     // RULE_13

	// mode 2 oversample at a fixed fraction of the clock
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
			m2_pre <= '0;
		else if (m2_os)
			m2_pre <= '0;
		else
			m2_pre <= m2_pre + 2'h1;
	end

	assign m2_os = (m2_pre == (cfg.double_rate_sel ? M2_FAST_LAST : M2_SLOW_LAST)); // RULE_24

	// timer 2 baud counter: clk/2 or external falling edges, auto reload
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			t2_half  <= 1'b0;
			t2_ext_q <= 1'b1;
			t2_cnt   <= '0;
		end
		else
		begin
			t2_half  <= ~t2_half;                               // RULE_23
			t2_ext_q <= t2_ext_i;
			if (!(cfg.tx_timer2_select | cfg.rx_timer2_select))
				t2_cnt <= timer2_reload;                         // held while unused
			else if (t2_ovf)
				t2_cnt <= timer2_reload;                         // RULE_15
			else if (t2_adv)
				t2_cnt <= t2_cnt + 16'h0001;
		end
	end

	assign t2_adv = cfg.timer2_ext_count ? (t2_ext_q & ~t2_ext_i) : t2_half; // RULE_23
	assign t2_ovf = t2_adv & (t2_cnt == T2_MAX) & (cfg.tx_timer2_select | cfg.rx_timer2_select);

	// per-direction oversample ticks
	assign tx_os = (mode == MODE2) ? m2_os : (cfg.tx_timer2_select ? t2_ovf : t1_os); // RULE_15
	assign rx_os = (mode == MODE2) ? m2_os : (cfg.rx_timer2_select ? t2_ovf : t1_os); // RULE_22

	// transmit divide-by-16, free running
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
			tx_div <= '0;
		else if (tx_os)
			tx_div <= tx_div + 4'h1;                             // RULE_12
	end

	assign tx_roll = tx_os & (tx_div == OS_LAST);

	// ---------------- transmitter and mode 0 shifter ----------------

	assign tx_last    = (mode == MODE1) ? STOP_BIT_10 : STOP_BIT_11;
	assign m0_last    = serial_control.multiproc_filter ? M0_FAST_LAST : M0_SLOW_LAST; // RULE_08
	assign m0_half    = serial_control.multiproc_filter ? M0_FAST_HALF : M0_SLOW_HALF;
	assign stop_place = (tx_state == TX_SEND) & tx_roll & (tx_bit + 4'h1 == tx_last);
	assign m0_tx_end  = (tx_state == TX_SYNC) & ~m0_rx & (m0_cnt == m0_last) & (tx_bit == M0_LAST_BIT);

	// transmit state machine; also runs mode 0 in both directions
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			tx_state   <= TX_IDLE;
			tx_sh      <= '1;
			tx_bit     <= '0;
			m0_cnt     <= '0;
			m0_rx      <= 1'b0;
			m0_rx_done <= 1'b0;
			txd_o      <= 1'b1;
			rxd_o      <= 1'b1;
			rxd_oe_o   <= 1'b0;
		end
		else
		begin
			m0_rx_done <= 1'b0;
			case (tx_state)
				TX_IDLE:
				begin
					txd_o    <= 1'b1;
					rxd_oe_o <= 1'b0;
					tx_bit   <= '0;
					m0_cnt   <= '0;
					if (data_wr && mode == MODE0)
					begin
						tx_sh    <= {3'b111, hwdata_i[7:0]};  // RULE_09
						m0_rx    <= 1'b0;
						tx_state <= TX_SYNC;
					end
					else if (data_wr)
					begin
						// stop, ninth (or stop again), data, start
						tx_sh    <= {1'b1, (mode == MODE1) ? 1'b1 : serial_control.tx_ninth_bit,
							hwdata_i[7:0], 1'b0};                // RULE_04
						tx_state <= TX_WAIT;
					end
					else if (mode == MODE0 && serial_control.rx_enable
						&& !serial_control.receive_done_flag && !m0_rx_done)
					begin
						m0_rx    <= 1'b1;                        // RULE_10
						tx_state <= TX_SYNC;
					end
				end
				TX_WAIT:
				begin
					if (tx_roll)                                 // RULE_16
					begin
						txd_o    <= tx_sh[0];
						tx_sh    <= {1'b1, tx_sh[10:1]};
						tx_bit   <= '0;
						tx_state <= TX_SEND;
					end
				end
				TX_SEND:
				begin
					if (tx_roll)
					begin
						if (tx_bit == tx_last)
							tx_state <= TX_IDLE;             // stop bit complete
						else
						begin
							txd_o  <= tx_sh[0];              // RULE_11
							tx_sh  <= {1'b1, tx_sh[10:1]};
							tx_bit <= tx_bit + 4'h1;
						end
					end
				end
				TX_SYNC:
				begin
					rxd_oe_o <= ~m0_rx;
					if (m0_cnt == '0)
					begin
						txd_o <= 1'b0;                          // shift clock low
						if (!m0_rx)
							rxd_o <= tx_sh[0];                  // RULE_09
					end
					if (m0_cnt == m0_half)
					begin
						txd_o <= 1'b1;                          // rising shift clock
						if (m0_rx)
							tx_sh[7:0] <= {rxd_i, tx_sh[7:1]};  // RULE_10
					end
					if (m0_cnt == m0_last)
					begin
						m0_cnt <= '0;
						if (!m0_rx)
							tx_sh <= {1'b1, tx_sh[10:1]};
						if (tx_bit == M0_LAST_BIT)
						begin
							m0_rx_done <= m0_rx;                // flag one cycle later
							rxd_o      <= 1'b1;
							tx_state   <= TX_IDLE;
						end
						else
							tx_bit <= tx_bit + 4'h1;
					end
					else
						m0_cnt <= m0_cnt + 4'h1;                // RULE_08
				end
				default:
					tx_state <= TX_IDLE;
			endcase
		end
	end

	// mode 1 done is delayed two clocks after the stop bit appears
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
			ti_dly <= '0;
		else
			ti_dly <= {ti_dly[TI_DELAY-2:0], stop_place & (mode == MODE1)}; // RULE_17
	end

	assign ti_set = (stop_place & (mode != MODE1)) | ti_dly[TI_DELAY-1] | m0_tx_end; // RULE_06 RULE_21

	// ---------------- asynchronous receiver ----------------

	assign rx_stop   = (mode == MODE1) ? STOP_BIT_10 : STOP_BIT_11;
	assign vote      = (smp_a & smp_b) | (smp_a & rxd_i) | (smp_b & rxd_i); // RULE_19
	assign flag_bit  = (mode == MODE1) ? vote : rx_ninth;                  // RULE_25
	assign rx_accept = (rx_state == RX_ASYNC) & rx_os & (rx_div == OS_MID_C) & (rx_bit == rx_stop)
		& ~serial_control.receive_done_flag
		& (~serial_control.multiproc_filter | flag_bit);                   // RULE_20 RULE_02
	assign ri_set    = rx_accept | m0_rx_done;                             // RULE_10

	// receive state machine, sixteen samples per bit
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			rx_state <= RX_IDLE;
			rx_div   <= '0;
			rx_bit   <= '0;
			rx_prev  <= 1'b1;
			smp_a    <= 1'b1;
			smp_b    <= 1'b1;
			rx_sh    <= '0;
			rx_ninth <= 1'b0;
		end
		else if (mode == MODE0 || !serial_control.rx_enable)              // RULE_03
		begin
			rx_state <= RX_IDLE;
			rx_prev  <= 1'b1;
		end
		else if (rx_os)                                                   // RULE_18
		begin
			rx_prev <= rxd_i;
			case (rx_state)
				RX_IDLE:
				begin
					if (rx_prev && !rxd_i)
					begin
						rx_div   <= 4'h1;                  // this sample is count zero
						rx_bit   <= '0;
						rx_state <= RX_ASYNC;              // RULE_18
					end
				end
				RX_ASYNC:
				begin
					rx_div <= rx_div + 4'h1;
					if (rx_div == OS_LAST)
						rx_bit <= rx_bit + 4'h1;
					if (rx_div == OS_MID_A)
						smp_a <= rxd_i;
					if (rx_div == OS_MID_B)
						smp_b <= rxd_i;
					if (rx_div == OS_MID_C)
					begin
						if (rx_bit == '0 && vote)
							rx_state <= RX_IDLE;           // RULE_19
						else if (rx_bit == rx_stop)
							rx_state <= RX_IDLE;           // RULE_20
						else if (rx_bit == NINTH_BIT)
							rx_ninth <= vote;
						else if (rx_bit != '0 && rx_bit <= DATA_LAST)
							rx_sh <= {vote, rx_sh[7:1]};   // lsb first
					end
				end
				default:
					rx_state <= RX_IDLE;
			endcase
		end
	end

	// received byte buffer
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
			serial_data_buffer <= '0;
		else if (rx_accept)
			serial_data_buffer <= rx_sh;                               // RULE_20
		else if (m0_rx_done)
			serial_data_buffer <= tx_sh[7:0];
	end

endmodule // sfp_serial_port

//--- verification/sfp_serial_port_properties.sv
// port-level checker of the four-mode serial port
`timescale 1ns/1ps
module sfp_props
(
	input wire logic                       ref_clk_i,
	input wire logic                       srst_i,
	input wire logic                       hsel_i,
	input wire logic [1:0]                 htrans_i,
	input wire logic                       hwrite_i,
	input wire logic                       hready_i,
	input wire logic [sfp_pkg::DATA_W-1:0] hrdata_o,
	input wire logic                       hreadyout_o,
	input wire logic                       hresp_o,
	input wire logic                       txd_o,
	input wire logic                       rxd_o,
	input wire logic                       rxd_oe_o,
	input wire logic                       timer1_tick_o,
	input wire logic                       serial_irq_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);
	// zero-wait slave with okay response
	a_bus_ready: assert property (hreadyout_o && !hresp_o) else $error("bus not ready");
	a_rdata_idle: assert property (!(hsel_i && hready_i && htrans_i[1] && !hwrite_i) |=> hrdata_o == '0)
		else $error("read data without read");
	a_rdata_upper: assert property (hrdata_o[31:16] == '0) else $error("upper read bits set");
	// outputs idle after reset
	a_reset_idle: assert property (disable iff (1'b0) srst_i |=> txd_o && rxd_o && !rxd_oe_o && !serial_irq_o)
		else $error("outputs not idle after reset");
	a_tick_gap: assert property (timer1_tick_o |=> !timer1_tick_o [*3]) else $error("timer tick too close");
	// shift clock halves last 2 or 6 clocks
	a_m0_clk_low: assert property ($fell(txd_o) && rxd_oe_o |-> !txd_o [*2] ##[1:5] txd_o)
		else $error("shift clock low phase wrong");
	a_m0_clk_high: assert property ($rose(txd_o) && rxd_oe_o |-> txd_o [*2]) else $error("shift clock high short");
	a_oe_end_idle: assert property ($fell(rxd_oe_o) |-> txd_o) else $error("shift clock not idle at end");
	c_shift: cover property (rxd_oe_o);
	c_irq: cover property (serial_irq_o);
	c_tick: cover property (timer1_tick_o);
endmodule // sfp_props

//--- verification/sfp_line_model.sv
// remote serial device: sends frames and captures frames
`timescale 1ns/1ps
module sfp_line_model
(
	input  wire logic clk_i,
	input  wire logic txd_i,
	output logic      rxd_o
);
	int          per = 64;    // clocks per bit
	int          nb = 11;     // bits per frame
	int          frames = 0;  // frames captured
	logic [10:0] fr;          // last frame, start bit at 0
	initial rxd_o = 1'b1;
	// capture each bit at its middle
	always
	begin
		@(negedge txd_i);
		fr = '0;
		repeat (per / 2) @(posedge clk_i);
		for (int i = 0; i < nb; i++)
		begin
			fr[i] = txd_i;
			repeat (per) @(posedge clk_i);
		end
		frames++;
	end
	// send lsb first, then idle high
	task send(input logic [10:0] f, input int n);
		for (int i = 0; i < n; i++)
		begin
			rxd_o <= f[i];
			repeat (per) @(posedge clk_i);
		end
		rxd_o <= 1'b1;
	endtask
endmodule // sfp_line_model

//--- verification/sfp_serial_port_tb_top.sv
// testbench of the four-mode serial port
`timescale 1ns/1ps
module sfp_serial_port_tb_top;
	import sfp_pkg::*;
	logic        clk, srst, hsel, hwrite, rdy, hresp, rxd, rxd_out, rxd_oe, txd, tick, irq;
	logic        t1_ovf = 1'b0;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata;
	int          error_cnt = 0, n_tests = 0, cyc = 0;
	sfp_serial_port i_sfp_serial_port (.ref_clk_i(clk), .srst_i(srst), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(rdy),
		.hrdata_o(hrdata), .hreadyout_o(rdy), .hresp_o(hresp), .rxd_i(rxd), .rxd_o(rxd_out),
		.rxd_oe_o(rxd_oe), .txd_o(txd), .timer1_ovf_i(t1_ovf), .t2_ext_i(1'b0),
		.timer1_tick_o(tick), .serial_irq_o(irq));
	sfp_line_model i_sfp_line_model (.clk_i(clk), .txd_i(txd), .rxd_o(rxd));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// timer 1 overflows on every count tick
	always @(posedge clk) t1_ovf <= tick;
	task tally_and_finish;
		$display("errors %0d, checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin error_cnt++; $display("MISMATCH %0t got %h want %h", $time, g, e); end
	endtask
	// one single ahb transfer, waits for ready in both phases
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		logic r;
		hsel <= 1'b1; haddr <= {24'h0, a}; hwrite <= w; htrans <= 2'b10;
		do begin @(negedge clk); r = rdy; @(posedge clk); end while (r !== 1'b1);
		hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
		do begin @(negedge clk); r = rdy; rd = hrdata; @(posedge clk); end while (r !== 1'b1);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		xfer(1'b1, a, d, x);
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		xfer(1'b0, a, '0, x);
		chk(x, e);
	endtask
	task t_regs;
		rd_chk(ADDR_CTRL, 32'h0);
		rd_chk(ADDR_CFG, 32'h0);
		wr(ADDR_RELOAD, 32'h1234);
		rd_chk(ADDR_RELOAD, 32'h1234);
		wr(8'h10, 32'hff);
		rd_chk(8'h10, 32'h0);
	endtask
	// async transmit captured by the far end
	task t_atx(input logic [7:0] c, input logic [7:0] g, input logic [15:0] rl, input int nb, input logic [10:0] f);
		int k;
		wr(ADDR_RELOAD, 32'(rl)); wr(ADDR_CFG, 32'(g)); wr(ADDR_CTRL, 32'(c));
		i_sfp_line_model.nb = nb;
		k = i_sfp_line_model.frames;
		wr(ADDR_DATA, 32'(f[8:1]));
		while (i_sfp_line_model.frames == k) @(posedge clk);
		chk(32'(i_sfp_line_model.fr), 32'(f));
		rd_chk(ADDR_CTRL, 32'(c | 8'h02));
	endtask
	// mode 2 receive with enables, filter and interrupt
	task t_arx(input logic [7:0] c, input logic n, input logic [7:0] e);
		wr(ADDR_CFG, 32'h60); wr(ADDR_CTRL, 32'(c));
		i_sfp_line_model.send({1'b1, n, 8'hc3, 1'b0}, 11);
		repeat (4) @(posedge clk);
		rd_chk(ADDR_CTRL, 32'(e));
		chk(32'(irq), 32'(e[0]));
		if (e[0]) rd_chk(ADDR_DATA, 32'hc3);
	endtask
	// mode 0 transmit at slow or fast shift rate
	task t_m0(input logic fast, input int per);
		logic [7:0] g;
		time t;
		wr(ADDR_CTRL, {26'h0, fast, 5'h0}); wr(ADDR_DATA, 32'h96);
		for (int i = 0; i < 8; i++) begin @(posedge txd); g[i] = rxd_out; if (i > 0) chk(32'($time - t), 32'(per * 10)); t = $time; end
		repeat (per) @(posedge clk);
		chk(32'(g), 32'h96);
		rd_chk(ADDR_CTRL, {26'h0, fast, 5'h02});
	endtask
	// mode 0 receive of the idle-high line, then halt
	task t_m0rx;
		wr(ADDR_CTRL, 32'h10);
		repeat (120) @(posedge clk);
		rd_chk(ADDR_CTRL, 32'h11);
		rd_chk(ADDR_DATA, 32'hff);
	endtask
	initial
	begin
		srst = 1'b1; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0; hwdata = '0;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		t_regs;
		t_atx(8'h88, 8'h00, 16'h0, 11, {2'b11, 8'ha5, 1'b0});
		t_atx(8'h40, 8'h03, 16'h0, 10, {2'b01, 8'h5a, 1'b0});
		t_atx(8'hc0, 8'h04, 16'hfffe, 11, {2'b10, 8'h3c, 1'b0});
		t_arx(8'hb0, 1'b0, 8'hb0);
		t_arx(8'hb0, 1'b1, 8'hb5);
		t_arx(8'ha0, 1'b1, 8'ha0);
		t_m0(1'b0, 12);
		t_m0(1'b1, 4);
		t_m0rx;
		tally_and_finish;
	end
	// hang guard
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin error_cnt++; tally_and_finish; end
	end
endmodule // sfp_serial_port_tb_top
bind sfp_serial_port sfp_props i_sfp_props (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .hsel_i(hsel_i),
	.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
	.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .txd_o(txd_o), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o),
	.timer1_tick_o(timer1_tick_o), .serial_irq_o(serial_irq_o));
